// ---- design/ppi_pkg.sv ----
package ppi_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	// Printed offsets are not all multiples of four, so they are indices.
	localparam logic [7:0] PPI_IDX_TRIG = 8'h9a;
	localparam logic [7:0] PPI_IDX_FLAG = 8'h9d;
	localparam logic [7:0] PPI_IDX_POL = 8'h9b;
	localparam logic [7:0] PPI_IDX_EN = 8'h9c;
	localparam logic [7:0] PPI_IDX_STAT = 8'h9e;
	localparam logic [11:0] PPI_ADDR_TRIG = {2'h0, PPI_IDX_TRIG, 2'h0};
	localparam logic [11:0] PPI_ADDR_FLAG = {2'h0, PPI_IDX_FLAG, 2'h0};
	localparam logic [11:0] PPI_ADDR_POL = {2'h0, PPI_IDX_POL, 2'h0};
	localparam logic [11:0] PPI_ADDR_EN = {2'h0, PPI_IDX_EN, 2'h0};
	localparam logic [11:0] PPI_ADDR_STAT = {2'h0, PPI_IDX_STAT, 2'h0};

	// ------------------------------------------------------------
	// Sizes and reset values
	// ------------------------------------------------------------
	localparam int PPI_PINS = 8;
	localparam logic [7:0] PPI_RST_TRIG = 8'h00;
	localparam logic [7:0] PPI_RST_POL = 8'h00;
	localparam logic [7:0] PPI_RST_FLAG = 8'h00;
	localparam logic [7:0] PPI_RST_EN = 8'h00;

	// Per-pin configuration carried together.
	typedef struct packed {
		logic [7:0] enable;
		logic [7:0] trig;
		logic [7:0] pol;
	} ppi_cfg_s;

endpackage : ppi_pkg

// ---- design/ppi_top.sv ----
// Chosen here: the APB register port.
`timescale 1ns/10ps
// What this block does
// - Eight separately configured detectors, one per first port pin.
// - A pin sets its flag only when its enable bit is one.
// - Trigger-type bit zero means level detection, one means edge.
// - Polarity zero picks low or falling, one picks high or rising.
// - All eight pins are sampled on every clock cycle.
// - Level events need the chosen level in two consecutive samples.
// - Edge events need a change in chosen direction between samples.
// - A detected event on an enabled pin sets its flag bit.
// - Only software clears flags; hardware never clears them.
// - Any detected event on an enabled pin raises a wake request from power-down.
// - Trigger, polarity and flag registers reset to zero.
module ppi_top
	import ppi_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] first_port_pin,
	output logic pin_event_interrupt,
	output logic wake_request
);

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	ppi_cfg_s cfg_q;
	logic [7:0] flags_q;
	logic [7:0] samp_q;
	logic [7:0] prev_q;
	logic [7:0] event_d;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic irq_q;
	logic wake_q;
	logic wr_en;
	logic rd_en;
	logic [7:0] clr_mask;
	logic pready_q;

	// Decodes a byte address into a mapped/unmapped answer.
	function automatic logic ppi_mapped(input logic [11:0] a);
		if (a == PPI_ADDR_TRIG) begin
			return 1'b1;
		end else if (a == PPI_ADDR_POL) begin
			return 1'b1;
		end else if (a == PPI_ADDR_EN) begin
			return 1'b1;
		end else if (a == PPI_ADDR_FLAG) begin
			return 1'b1;
		end else if (a == PPI_ADDR_STAT) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction : ppi_mapped

	// A write lands at the access edge; a read is fetched at the setup
	// edge so that its data already stands when the access phase opens.
	assign wr_en = psel && penable && pwrite && pstrb[0];
	assign rd_en = psel && !penable && !pwrite;

	// ------------------------------------------------------------
	// Pin sampling
	// ------------------------------------------------------------
	// Two stages give the current and previous sample for each pin.
	// Pins are taken as synchronous, so the first stage is already a
	// clean sample; a slower source must hold each level for at least
	// two clocks or a level event may be missed.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samp_q <= 8'h00;
			prev_q <= 8'h00;
		end else begin
			samp_q <= first_port_pin;
			prev_q <= samp_q;
		end
	end

	// ------------------------------------------------------------
	// Per-pin detectors
	// ------------------------------------------------------------
	// Each pin compares two consecutive samples against its mode.
	// Changing the mode or polarity while a pin is active can itself
	// look like an event; software should clear the flags afterwards.
	generate
		for (genvar i = 0; i < PPI_PINS; i++) begin : g_det
			always_comb begin
				if (cfg_q.trig[i]) begin
					// Edge: previous differs, current matches polarity.
					event_d[i] = (samp_q[i] == cfg_q.pol[i]) &&
						(prev_q[i] != cfg_q.pol[i]);
				end else begin
					// Level: both samples at the selected level.
					event_d[i] = (samp_q[i] == cfg_q.pol[i]) &&
						(prev_q[i] == cfg_q.pol[i]);
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	// Only the low byte of a write is used; a write to an unmapped or
	// read-only word leaves every register as it was. Enable resets to
	// zero so that no pin can fire before software has set it up.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q.trig <= PPI_RST_TRIG;
			cfg_q.pol <= PPI_RST_POL;
			cfg_q.enable <= PPI_RST_EN;
		end else if (wr_en) begin
			if (paddr == PPI_ADDR_TRIG) begin
				cfg_q.trig <= pwdata[7:0];
			end else if (paddr == PPI_ADDR_POL) begin
				cfg_q.pol <= pwdata[7:0];
			end else if (paddr == PPI_ADDR_EN) begin
				cfg_q.enable <= pwdata[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Flags
	// ------------------------------------------------------------
	// Software clears by writing zero to a flag bit; writing one keeps
	// it. A new event in the same cycle wins over the clear.
	assign clr_mask = (wr_en && paddr == PPI_ADDR_FLAG) ?
		~pwdata[7:0] : 8'h00;

	// A level that is still present sets its flag again at once, so a
	// level source must be removed before its flag is cleared.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= PPI_RST_FLAG;
		end else begin
			flags_q <= (flags_q & ~clr_mask) |
				(event_d & cfg_q.enable);
		end
	end

	// Single request and wake both come from registers. The request is
	// built from the next flag value, so it never lags the flags.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			irq_q <= |((flags_q & ~clr_mask) | (event_d & cfg_q.enable));
			wake_q <= |(event_d & cfg_q.enable);
		end
	end

	// ------------------------------------------------------------
	// APB read path
	// ------------------------------------------------------------
	// Read data is fetched at the setup edge and then stands until the
	// next read is set up. Unmapped words read zero and raise an error.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= psel && !penable && !ppi_mapped(paddr);
			if (rd_en) begin
				if (paddr == PPI_ADDR_TRIG) begin
					prdata_q <= {24'h000000, cfg_q.trig};
				end else if (paddr == PPI_ADDR_POL) begin
					prdata_q <= {24'h000000, cfg_q.pol};
				end else if (paddr == PPI_ADDR_EN) begin
					prdata_q <= {24'h000000, cfg_q.enable};
				end else if (paddr == PPI_ADDR_FLAG) begin
					prdata_q <= {24'h000000, flags_q};
				end else if (paddr == PPI_ADDR_STAT) begin
					prdata_q <= {24'h000000, samp_q};
				end else begin
					prdata_q <= 32'h0000_0000;
				end
			end
		end
	end

	// Ready is raised for exactly the access phase that follows a setup
	// cycle, so every transfer ends without wait states.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= psel && !penable;
		end
	end

	// Every output is a plain copy of a register.
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign pready = pready_q;
	assign pin_event_interrupt = irq_q;
	assign wake_request = wake_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// The per-pin checks are repeated for every pin, so a fault that
	// hits only one bit of a register cannot slip through unseen.
	generate
		for (genvar k = 0; k < PPI_PINS; k++) begin : g_chk
			// Two samples at the chosen level set the flag next cycle.
			a_level_two_samples: assert property (
				@(posedge pclk) disable iff (!presetn)
				(!cfg_q.trig[k] && cfg_q.enable[k] &&
				samp_q[k] == cfg_q.pol[k] &&
				prev_q[k] == cfg_q.pol[k]) |=> flags_q[k])
				else $error("level event did not set flag");

			// A low-to-high step sets the flag when rising is chosen.
			a_edge_rise_sets: assert property (
				@(posedge pclk) disable iff (!presetn)
				(cfg_q.trig[k] && cfg_q.pol[k] && cfg_q.enable[k] &&
				samp_q[k] && !prev_q[k]) |=> flags_q[k])
				else $error("rising edge did not set flag");

			// A high-to-low step sets the flag when falling is chosen.
			a_edge_fall_sets: assert property (
				@(posedge pclk) disable iff (!presetn)
				(cfg_q.trig[k] && !cfg_q.pol[k] && cfg_q.enable[k] &&
				!samp_q[k] && prev_q[k]) |=> flags_q[k])
				else $error("falling edge did not set flag");

			// A steady pin never makes an edge event.
			a_edge_steady: assert property (
				@(posedge pclk) disable iff (!presetn)
				(cfg_q.trig[k] && samp_q[k] == prev_q[k]) |-> !event_d[k])
				else $error("edge mode fired on a steady pin");

			// A pin whose enable is zero never raises its flag.
			a_disabled_no_set: assert property (
				@(posedge pclk) disable iff (!presetn)
				(!cfg_q.enable[k] && !flags_q[k]) |=> !flags_q[k])
				else $error("disabled pin raised flag");

			// Only a software write to the flag register drops a flag.
			a_flag_holds: assert property (
				@(posedge pclk) disable iff (!presetn)
				(flags_q[k] && !(wr_en && paddr == PPI_ADDR_FLAG))
				|=> flags_q[k])
				else $error("flag cleared by hardware");

			// Writing zero clears a flag unless a new event arrives.
			a_flag_clears: assert property (
				@(posedge pclk) disable iff (!presetn)
				(wr_en && paddr == PPI_ADDR_FLAG && !pwdata[k] &&
				!(event_d[k] && cfg_q.enable[k])) |=> !flags_q[k])
				else $error("software clear did not take");

			// A flag only rises after an enabled event.
			a_flag_cause: assert property (
				@(posedge pclk) disable iff (!presetn)
				$rose(flags_q[k]) |-> $past(event_d[k] && cfg_q.enable[k]))
				else $error("flag set without event");

			// An enabled event always leaves its flag set.
			a_event_sets: assert property (
				@(posedge pclk) disable iff (!presetn)
				(event_d[k] && cfg_q.enable[k]) |=> flags_q[k])
				else $error("enabled event lost");

			// In level mode one differing sample is never enough.
			a_level_single: assert property (
				@(posedge pclk) disable iff (!presetn)
				(!cfg_q.trig[k] && samp_q[k] != prev_q[k]) |-> !event_d[k])
				else $error("level mode fired on one sample");

			// A low or falling choice never fires on a high sample.
			a_falling_pol: assert property (
				@(posedge pclk) disable iff (!presetn)
				(!cfg_q.pol[k] && samp_q[k]) |-> !event_d[k])
				else $error("low choice fired on high sample");

			// A high or rising choice never fires on a low sample.
			a_rising_pol: assert property (
				@(posedge pclk) disable iff (!presetn)
				(cfg_q.pol[k] && !samp_q[k]) |-> !event_d[k])
				else $error("high choice fired on low sample");
		end
	endgenerate

	// The single request stands while any flag is set.
	a_irq_follows: assert property (
		@(posedge pclk) disable iff (!presetn)
		(|flags_q) |-> ##[0:1] pin_event_interrupt)
		else $error("request missing while flag set");

	// The request drops with the last flag, so none is left hanging.
	a_irq_matches: assert property (
		@(posedge pclk) disable iff (!presetn)
		pin_event_interrupt == (|flags_q))
		else $error("request differs from flags");

	// Every enabled event asks for a wake on the next cycle.
	a_wake_event: assert property (
		@(posedge pclk) disable iff (!presetn)
		(|(event_d & cfg_q.enable)) |=> wake_request)
		else $error("event did not request wake");

	// A wake pulse always has an enabled event behind it.
	a_wake_cause: assert property (
		@(posedge pclk) disable iff (!presetn)
		wake_request |-> $past(|(event_d & cfg_q.enable)))
		else $error("wake without event");

	// Each pin moves through both sample stages one clock apart; the
	// first cycle after reset is skipped, as the stages were held then.
	a_sample_chain: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(presetn) |-> (samp_q == $past(first_port_pin) &&
		prev_q == $past(samp_q)))
		else $error("pin sampling lost a cycle");

	// The status word shows the first sample stage of every pin.
	a_read_status: assert property (
		@(posedge pclk) disable iff (!presetn)
		(rd_en && paddr == PPI_ADDR_STAT) |=> prdata[7:0] == $past(samp_q))
		else $error("status read returned wrong value");

	// A flag read returns the flags as they stood at the setup edge.
	a_read_flags: assert property (
		@(posedge pclk) disable iff (!presetn)
		(rd_en && paddr == PPI_ADDR_FLAG) |=> prdata[7:0] == $past(flags_q))
		else $error("flag read returned wrong value");

	// Trigger, polarity and flags are all zero straight after reset.
	a_reset_zero: assert property (
		@(posedge pclk) $rose(presetn) |-> (flags_q == 8'h00 &&
		cfg_q.trig == 8'h00 && cfg_q.pol == 8'h00))
		else $error("registers not zero after reset");

endmodule : ppi_top

// ---- tb/ppi_pin_src.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Outside pin source
// ------------------------------------------------------------
// Drives the port pins one edge after the bench asks for a level.
// Every level is held for whole cycles, so each one is sampled.
module ppi_pin_src (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] want,
	output logic [7:0] pin
);
	// Pins rest high; a level changes only at a rising edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin <= 8'hff;
		end else begin
			pin <= want;
		end
	end
endmodule : ppi_pin_src

// ---- tb/test_port_pin_interrupt_detector.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module test_port_pin_interrupt_detector;
	import ppi_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pin_event_interrupt;
	logic pready, pslverr, wake_request;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] want, first_port_pin;
	int miscompares, num_checks, wakes;

	ppi_top ppi_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.first_port_pin(first_port_pin),
		.pin_event_interrupt(pin_event_interrupt),
		.wake_request(wake_request));
	ppi_pin_src ppi_pin_src_inst (.pclk(pclk), .presetn(presetn),
		.want(want), .pin(first_port_pin));

	// A wake request stays high while an enabled event lasts, so each high cycle is counted.
	always @(posedge pclk) begin
		if (wake_request === 1'b1) wakes++;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; the request is held until pready is seen high.
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask : xfer

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		xfer(1'b1, a, {24'h0, d}, q, e);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		logic [31:0] q;
		logic e;
		xfer(1'b0, a, 32'h0, q, e);
		chk({q, 31'h0, e}, {24'h0, exp, 32'h0});
	endtask : rd

	// Sets the pins, then lets detection and the flag settle.
	task automatic pins(input logic [7:0] v);
		@(posedge pclk);
		want <= v;
		repeat (6) @(posedge pclk);
	endtask : pins

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] q;
		logic e;
		rd(PPI_ADDR_TRIG, 8'h00);
		rd(PPI_ADDR_POL, 8'h00);
		rd(PPI_ADDR_FLAG, 8'h00);
		rd(PPI_ADDR_EN, 8'h00);
		xfer(1'b0, 12'h000, 32'h0, q, e);
		chk({q, 31'h0, e}, {32'h0, 32'h1});
	endtask : t_reset

	// Bit 0 rising, bit 1 falling; bit 2 toggles while disabled.
	task automatic t_edge();
		int w0;
		pins(8'h02);
		wr(PPI_ADDR_TRIG, 8'hff);
		wr(PPI_ADDR_POL, 8'h01);
		wr(PPI_ADDR_EN, 8'h03);
		wr(PPI_ADDR_FLAG, 8'h00);
		rd(PPI_ADDR_FLAG, 8'h00);
		w0 = wakes;
		pins(8'h05);
		rd(PPI_ADDR_FLAG, 8'h03);
		rd(PPI_ADDR_STAT, 8'h05);
		chk(pin_event_interrupt, 1'b1);
		chk(wakes > w0, 1'b1);
		pins(8'h02);
		rd(PPI_ADDR_FLAG, 8'h03);
		wr(PPI_ADDR_FLAG, 8'h00);
		pins(8'h05);
		pins(8'h02);
		wr(PPI_ADDR_FLAG, 8'h00);
		repeat (3) @(posedge pclk);
		rd(PPI_ADDR_FLAG, 8'h00);
		chk(pin_event_interrupt, 1'b0);
	endtask : t_edge

	// Bit 0 low level, bit 7 high level; one-sample glitches must not count.
	task automatic t_level();
		pins(8'h01);
		wr(PPI_ADDR_TRIG, 8'h00);
		wr(PPI_ADDR_POL, 8'h80);
		wr(PPI_ADDR_EN, 8'h81);
		wr(PPI_ADDR_FLAG, 8'h00);
		rd(PPI_ADDR_POL, 8'h80);
		rd(PPI_ADDR_FLAG, 8'h00);
		@(posedge pclk);
		want <= 8'h80;
		@(posedge pclk);
		want <= 8'h01;
		repeat (6) @(posedge pclk);
		rd(PPI_ADDR_FLAG, 8'h00);
		pins(8'h80);
		pins(8'h01);
		rd(PPI_ADDR_FLAG, 8'h81);
		wr(PPI_ADDR_FLAG, 8'h00);
		rd(PPI_ADDR_FLAG, 8'h00);
	endtask : t_level

	// ------------------------------------------------------------
	// Run control
	// ------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// The scenarios take well under 1000 cycles; this cuts a hang short.
	initial begin
		#100000;
		$display("ERROR %0t watchdog expired", $time);
		miscompares++;
		tally_and_finish();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{want, miscompares, num_checks, wakes} = {8'hff, 96'h0};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_edge();
		t_level();
		tally_and_finish();
	end
endmodule : test_port_pin_interrupt_detector
